// ### common/bmg_regs.svh
// Register offsets, field positions, reset values and fixed output levels
// of the backup mode output gating block.
// Assumes a 32-bit AHB-Lite slave with one aligned word per register.
`ifndef BMG_REGS_SVH
`define BMG_REGS_SVH

// Byte offsets inside the slave window
`define BMG_ADDR_W          12
`define BMG_OFF_STATUS      12'h000
`define BMG_OFF_IRQ_EN      12'h004
`define BMG_OFF_IRQ_CLR     12'h008
`define BMG_OFF_LEVELS      12'h00c
`define BMG_OFF_BACKUP_CNT  12'h010

// Event bits, shared by status, enable and clear
`define BMG_EVT_W           4
`define BMG_EVT_BACKUP_IN   0
`define BMG_EVT_BACKUP_OUT  1
`define BMG_EVT_PFAIL       2
`define BMG_EVT_SUPPLY_LOW  3

// Live level bits
`define BMG_LVL_BACKUP      0
`define BMG_LVL_SUPPLY_LOW  1
`define BMG_LVL_PFAIL       2
`define BMG_LVL_CE_FORCED   3

// Reset values
`define BMG_RST_WORD        32'h0000_0000
`define BMG_RST_EVT         4'h0
`define BMG_RST_CNT         16'h0000
`define BMG_CNT_ONE         16'h0001
// Back-up entry counter stops here rather than wrapping
`define BMG_CNT_MAX         16'hffff

// Levels forced in battery back-up mode
`define BMG_BK_BACKUP_FLAG  1'b1
`define BMG_BK_PFAIL_N      1'b0
`define BMG_BK_RESET_N      1'b0
`define BMG_BK_SUPPLY_OK    1'b0
`define BMG_BK_WD_EXP_N     1'b1
`define BMG_BK_CE_N         1'b1
`define BMG_BK_KICK         1'b0
`define BMG_BK_TIMEBASE     1'b0
`define BMG_BK_TB_SELECT    1'b1

// AHB encodings
`define BMG_HTRANS_NONSEQ_BIT 1
`define BMG_HRESP_OKAY      1'b0

`endif

// ### common/bmg_pkg.sv
// Types of the backup mode output gating block.
// Assumes the constants of bmg_regs.svh are included where numbers are needed.
package bmg_pkg;

	typedef enum logic {
		BMG_MODE_NORMAL,
		BMG_MODE_BACKUP
	} bmg_mode_t;

	typedef logic [3:0] bmg_evt_t;

endpackage

// ### hw/bmg_out_stage.sv
// Output stage: forces fixed levels in back-up mode, gates chip enable,
// and registers every pin output.
// Assumes comparator and control inputs are synchronous to clk_sys.
`timescale 1ns/10ps
`include "bmg_regs.svh"

module bmg_out_stage (
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic backup_mode,
	input  wire logic supply_below_reset,
	input  wire logic pfail_below_ref,
	input  wire logic chip_enable_in_n,
	input  wire logic reset_req_n,
	input  wire logic watchdog_exp_req_n,
	input  wire logic watchdog_kick_in,
	input  wire logic timebase_in,
	input  wire logic timebase_select,
	output logic      backup_active_flag,
	output logic      power_fail_warn_n,
	output logic      reset_out_n,
	output logic      reset_out,
	output logic      supply_ok_n_low,
	output logic      watchdog_expired_n,
	output logic      chip_enable_out_n,
	output logic      watchdog_kick_out,
	output logic      timebase_out,
	output logic      timebase_select_out
);

	////////////////////////////////////////////////////////////////////////////////
	logic batt_reg, batt_next;
	logic pfo_reg, pfo_next;
	logic rst_reg, rst_next;
	logic low_reg, low_next;
	logic wdo_reg, wdo_next;
	logic ce_reg, ce_next;
	logic kick_reg, kick_next;
	logic tb_reg, tb_next;
	logic tbs_reg, tbs_next;

	always_comb begin
		batt_next = 1'b0;
		pfo_next  = ~pfail_below_ref;
		rst_next  = reset_req_n;
		low_next  = ~supply_below_reset;
		wdo_next  = watchdog_exp_req_n;
		ce_next   = chip_enable_in_n;
		kick_next = watchdog_kick_in;
		tb_next   = timebase_in;
		tbs_next  = timebase_select;
		// A bad supply write-protects memory even before back-up mode is reached
		if (supply_below_reset) begin
			ce_next = `BMG_BK_CE_N;
		end
		if (backup_mode) begin
			batt_next = `BMG_BK_BACKUP_FLAG;
			pfo_next  = `BMG_BK_PFAIL_N;
			rst_next  = `BMG_BK_RESET_N;
			low_next  = `BMG_BK_SUPPLY_OK;
			wdo_next  = `BMG_BK_WD_EXP_N;
			ce_next   = `BMG_BK_CE_N;
			kick_next = `BMG_BK_KICK;
			tb_next   = `BMG_BK_TIMEBASE;
			tbs_next  = `BMG_BK_TB_SELECT;
		end
	end

	// Reset holds the memory protected and the processor in reset
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			batt_reg <= 1'b0;
			pfo_reg  <= 1'b0;
			rst_reg  <= 1'b0;
			low_reg  <= 1'b0;
			wdo_reg  <= 1'b1;
			ce_reg   <= 1'b1;
			kick_reg <= 1'b0;
			tb_reg   <= 1'b0;
			tbs_reg  <= 1'b1;
		end else begin
			batt_reg <= batt_next;
			pfo_reg  <= pfo_next;
			rst_reg  <= rst_next;
			low_reg  <= low_next;
			wdo_reg  <= wdo_next;
			ce_reg   <= ce_next;
			kick_reg <= kick_next;
			tb_reg   <= tb_next;
			tbs_reg  <= tbs_next;
		end
	end

	assign backup_active_flag  = batt_reg;
	assign power_fail_warn_n   = pfo_reg;
	assign reset_out_n         = rst_reg;
	assign reset_out           = ~rst_reg;
	assign supply_ok_n_low     = low_reg;
	assign watchdog_expired_n  = wdo_reg;
	assign chip_enable_out_n   = ce_reg;
	assign watchdog_kick_out   = kick_reg;
	assign timebase_out        = tb_reg;
	assign timebase_select_out = tbs_reg;

endmodule

// ### hw/bmg_top.sv
// Backup mode output gating: mode tracking, event capture, interrupt and
// AHB-Lite register slave, around the registered output stage.
// Assumes comparator outputs are synchronous levels and that the reset
// timer and watchdog that feed reset_req_n and watchdog_exp_req_n sit outside.
//
// Notes on behaviour
// - Valid supply: chip enable out copies input
// - Low or backup supply: chip enable forced high
// - Backup mode drives fixed documented output levels
// - Backup mode ignores power-fail sense input
// - Backup mode ignores kick and timebase inputs
// - Backup mode ignores chip enable input
// - Backup entered within 50mV, left when cleared
// - Power-fail warning low below 1.3V reference
// - Warning follows comparator, no hysteresis added
// - Active-high reset inverts active-low reset
// - Supply-low flag low below reset threshold
`timescale 1ns/10ps
`include "bmg_regs.svh"

module bmg_top (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// Comparator results
	input  wire logic        supply_below_reset,
	input  wire logic        switchover_comparator,
	input  wire logic        power_fail_comparator,
	// Pins from the processor side
	input  wire logic        chip_enable_in_n,
	input  wire logic        reset_req_n,
	input  wire logic        watchdog_exp_req_n,
	input  wire logic        watchdog_kick_in,
	input  wire logic        timebase_in,
	input  wire logic        timebase_select,
	// Pins to the processor, memory and timers
	output logic             backup_active_flag,
	output logic             power_fail_warn_n,
	output logic             reset_out_n,
	output logic             reset_out,
	output logic             supply_ok_n_low,
	output logic             watchdog_expired_n,
	output logic             chip_enable_out_n,
	output logic             watchdog_kick_out,
	output logic             timebase_out,
	output logic             timebase_select_out,
	output logic             irq,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp
);

	////////////////////////////////////////////////////////////////////////////////
	// Offset match, used by the read mux and the write decode
	function automatic logic reg_hit(input logic [`BMG_ADDR_W-1:0] addr,
	                                 input logic [`BMG_ADDR_W-1:0] offset);
		reg_hit = (addr == offset);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Mode tracking
	bmg_pkg::bmg_mode_t mode_reg, mode_next;
	logic               backup_mode;

	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			bmg_pkg::BMG_MODE_NORMAL: begin
				// The comparator asserts once the backup supply is within 50mV of the main one
				if (switchover_comparator) begin
					mode_next = bmg_pkg::BMG_MODE_BACKUP;
				end
			end
			bmg_pkg::BMG_MODE_BACKUP: begin
				if (!switchover_comparator) begin
					mode_next = bmg_pkg::BMG_MODE_NORMAL;
				end
			end
			default: begin
				mode_next = bmg_pkg::BMG_MODE_NORMAL;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			mode_reg <= bmg_pkg::BMG_MODE_NORMAL;
		end else begin
			mode_reg <= mode_next;
		end
	end

	// Using the comparator directly saves the output stage a cycle of latency
	assign backup_mode = switchover_comparator;

	////////////////////////////////////////////////////////////////////////////////
	// Output stage
	bmg_out_stage u_out (
		.clk_sys             (clk_sys),
		.rstn                (rstn),
		.backup_mode         (backup_mode),
		.supply_below_reset  (supply_below_reset | backup_mode),
		.pfail_below_ref     (power_fail_comparator),
		.chip_enable_in_n    (chip_enable_in_n),
		.reset_req_n         (reset_req_n),
		.watchdog_exp_req_n  (watchdog_exp_req_n),
		.watchdog_kick_in    (watchdog_kick_in),
		.timebase_in         (timebase_in),
		.timebase_select     (timebase_select),
		.backup_active_flag  (backup_active_flag),
		.power_fail_warn_n   (power_fail_warn_n),
		.reset_out_n         (reset_out_n),
		.reset_out           (reset_out),
		.supply_ok_n_low     (supply_ok_n_low),
		.watchdog_expired_n  (watchdog_expired_n),
		.chip_enable_out_n   (chip_enable_out_n),
		.watchdog_kick_out   (watchdog_kick_out),
		.timebase_out        (timebase_out),
		.timebase_select_out (timebase_select_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Event capture
	bmg_pkg::bmg_evt_t lvl_reg, lvl_next;
	bmg_pkg::bmg_evt_t rise;
	bmg_pkg::bmg_evt_t status_reg, status_next;
	bmg_pkg::bmg_evt_t irq_en_reg, irq_en_next;
	bmg_pkg::bmg_evt_t clr_bits;
	logic [15:0]       backup_cnt_reg, backup_cnt_next;
	logic              irq_reg, irq_next;

	always_comb begin
		lvl_next = `BMG_RST_EVT;
		lvl_next[`BMG_EVT_BACKUP_IN]  = backup_mode;
		lvl_next[`BMG_EVT_BACKUP_OUT] = ~backup_mode;
		// Power-fail sense is not looked at in back-up mode
		lvl_next[`BMG_EVT_PFAIL]      = power_fail_comparator & ~backup_mode;
		lvl_next[`BMG_EVT_SUPPLY_LOW] = supply_below_reset;
	end

	// One edge detector per event
	genvar gi;
	generate
		for (gi = 0; gi < `BMG_EVT_W; gi++) begin : g_evt
			assign rise[gi] = lvl_next[gi] & ~lvl_reg[gi];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero wait states, reads registered at the address phase
	logic                    acc_take;
	logic                    wr_pend_reg, wr_pend_next;
	logic [`BMG_ADDR_W-1:0]  wr_addr_reg, wr_addr_next;
	logic [31:0]             rdata_reg, rdata_next;
	logic [`BMG_ADDR_W-1:0]  a_addr;

	assign a_addr   = haddr[`BMG_ADDR_W-1:0];
	assign acc_take = hsel & htrans[`BMG_HTRANS_NONSEQ_BIT] & hready;

	always_comb begin
		wr_pend_next = acc_take & hwrite;
		wr_addr_next = acc_take ? a_addr : wr_addr_reg;
		rdata_next   = `BMG_RST_WORD;
		if (acc_take && !hwrite) begin
			if (reg_hit(a_addr, `BMG_OFF_STATUS)) begin
				rdata_next[`BMG_EVT_W-1:0] = status_reg;
			end else if (reg_hit(a_addr, `BMG_OFF_IRQ_EN)) begin
				rdata_next[`BMG_EVT_W-1:0] = irq_en_reg;
			end else if (reg_hit(a_addr, `BMG_OFF_LEVELS)) begin
				rdata_next[`BMG_LVL_BACKUP]     = backup_mode;
				rdata_next[`BMG_LVL_SUPPLY_LOW] = supply_below_reset;
				rdata_next[`BMG_LVL_PFAIL]      = power_fail_comparator & ~backup_mode;
				rdata_next[`BMG_LVL_CE_FORCED]  = supply_below_reset | backup_mode;
			end else if (reg_hit(a_addr, `BMG_OFF_BACKUP_CNT)) begin
				rdata_next[15:0] = backup_cnt_reg;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= `BMG_OFF_STATUS;
			rdata_reg   <= `BMG_RST_WORD;
		end else begin
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
			rdata_reg   <= rdata_next;
		end
	end

	assign hrdata    = rdata_reg;
	assign hreadyout = 1'b1;
	assign hresp     = `BMG_HRESP_OKAY;

	////////////////////////////////////////////////////////////////////////////////
	// Status, enable, clear and the back-up entry counter
	always_comb begin
		clr_bits    = `BMG_RST_EVT;
		irq_en_next = irq_en_reg;
		if (wr_pend_reg && reg_hit(wr_addr_reg, `BMG_OFF_IRQ_CLR)) begin
			clr_bits = hwdata[`BMG_EVT_W-1:0];
		end
		if (wr_pend_reg && reg_hit(wr_addr_reg, `BMG_OFF_IRQ_EN)) begin
			irq_en_next = hwdata[`BMG_EVT_W-1:0];
		end
		// A new event in the clearing cycle survives the clear
		status_next = (status_reg & ~clr_bits) | rise;
		backup_cnt_next = backup_cnt_reg;
		// Counter saturates so spurious switchover bursts never wrap to zero
		if ((mode_reg == bmg_pkg::BMG_MODE_NORMAL) && (mode_next == bmg_pkg::BMG_MODE_BACKUP)
				&& (backup_cnt_reg != `BMG_CNT_MAX)) begin
			backup_cnt_next = 16'(backup_cnt_reg + `BMG_CNT_ONE);
		end
		irq_next = |(status_next & irq_en_next);
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			lvl_reg        <= `BMG_RST_EVT;
			status_reg     <= `BMG_RST_EVT;
			irq_en_reg     <= `BMG_RST_EVT;
			backup_cnt_reg <= `BMG_RST_CNT;
			irq_reg        <= 1'b0;
		end else begin
			lvl_reg        <= lvl_next;
			status_reg     <= status_next;
			irq_en_reg     <= irq_en_next;
			backup_cnt_reg <= backup_cnt_next;
			irq_reg        <= irq_next;
		end
	end

	assign irq = irq_reg;

endmodule

// ### testbench/bmg_top_monitor.sv
// Checker of the pin relations of the back-up gating block.
// Assumes it is bound to bmg_top and sees its pins only.
`timescale 1ns/10ps
module bmg_top_monitor (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic supply_below_reset,
	input wire logic switchover_comparator,
	input wire logic power_fail_comparator,
	input wire logic chip_enable_in_n,
	input wire logic backup_active_flag,
	input wire logic power_fail_warn_n,
	input wire logic reset_out_n,
	input wire logic reset_out,
	input wire logic supply_ok_n_low,
	input wire logic watchdog_expired_n,
	input wire logic chip_enable_out_n,
	input wire logic watchdog_kick_out,
	input wire logic timebase_out,
	input wire logic timebase_select_out
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// Outputs lag one edge, so the first edge after reset still shows reset levels
	sequence live_s;
		rstn && $past(rstn);
	endsequence
	sequence bk_s;
		live_s ##0 $past(switchover_comparator);
	endsequence
	sequence norm_s;
		live_s ##0 !$past(switchover_comparator);
	endsequence
	a_ce_copy: assert property (norm_s ##0 !$past(supply_below_reset)
		|-> chip_enable_out_n == $past(chip_enable_in_n)) else $error("chip enable not copied");
	a_ce_forced: assert property (live_s ##0 $past(supply_below_reset || switchover_comparator)
		|-> chip_enable_out_n) else $error("chip enable not forced high");
	a_backup_levels: assert property (bk_s |-> backup_active_flag && !power_fail_warn_n && !reset_out_n
		&& !supply_ok_n_low && watchdog_expired_n && chip_enable_out_n) else $error("back-up levels wrong");
	a_pfail_ignored: assert property (bk_s ##0 $past(switchover_comparator, 2)
		|-> $stable(power_fail_warn_n)) else $error("warning moved in back-up");
	a_backup_quiet: assert property (bk_s |-> !watchdog_kick_out && !timebase_out
		&& timebase_select_out) else $error("timer pins not parked");
	a_ce_ignored: assert property (bk_s ##0 $past(switchover_comparator, 2)
		|-> $stable(chip_enable_out_n)) else $error("chip enable moved in back-up");
	a_mode_track: assert property (live_s |-> backup_active_flag == $past(switchover_comparator))
		else $error("back-up flag wrong");
	a_pfail_follow: assert property (norm_s |-> power_fail_warn_n == !$past(power_fail_comparator))
		else $error("warning does not follow sense");
	a_reset_pair: assert property (reset_out == !reset_out_n) else $error("reset pair not inverse");
	a_supply_flag: assert property (norm_s |-> supply_ok_n_low == !$past(supply_below_reset))
		else $error("supply flag wrong");
endmodule

bind bmg_top bmg_top_monitor u_mon (.clk_sys, .rstn, .supply_below_reset, .switchover_comparator,
	.power_fail_comparator, .chip_enable_in_n, .backup_active_flag, .power_fail_warn_n, .reset_out_n,
	.reset_out, .supply_ok_n_low, .watchdog_expired_n, .chip_enable_out_n, .watchdog_kick_out,
	.timebase_out, .timebase_select_out);

// ### testbench/bmg_cpu_model.sv
// Processor model: drives chip enable and the watchdog kick.
// Assumes clk_sys and the power-fail warning of the block.
`timescale 1ns/10ps
module bmg_cpu_model (
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic power_fail_warn_n,
	input  wire logic stray_drive,
	output logic      chip_enable_in_n,
	output logic      watchdog_kick_in
);
	logic ce_reg;
	logic ce_next;
	logic kick_reg;
	logic kick_next;
	always_comb begin
		// A warned processor parks memory access; a stray one keeps toggling
		ce_next = (power_fail_warn_n || stray_drive) ? !ce_reg : 1'b1;
		kick_next = !kick_reg;
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ce_reg <= 1'b1;
			kick_reg <= 1'b0;
		end else begin
			ce_reg <= ce_next;
			kick_reg <= kick_next;
		end
	end
	assign chip_enable_in_n = ce_reg;
	assign watchdog_kick_in = kick_reg;
endmodule

// ### testbench/bmg_top_tb.sv
// Self-checking bench of the back-up gating block: pins and registers.
// Assumes one 100 MHz clock and the processor model beside the block.
`timescale 1ns/10ps
`include "bmg_regs.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module bmg_top_tb;
	logic clk_sys = 1'b0, rstn = 1'b0, stray_drive = 1'b0;
	logic supply_below_reset = 1'b0, switchover_comparator = 1'b0, power_fail_comparator = 1'b0;
	logic reset_req_n = 1'b0, watchdog_exp_req_n = 1'b0, timebase_in = 1'b0, timebase_select = 1'b0;
	logic hsel = 1'b0, hwrite = 1'b0, pin_chk = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
	logic [3:0] cnt = 4'h0;
	logic [8:0] prev = 9'h000;
	logic backup_active_flag, power_fail_warn_n, reset_out_n, reset_out, supply_ok_n_low, watchdog_expired_n;
	logic chip_enable_out_n, watchdog_kick_out, timebase_out, timebase_select_out, irq, hreadyout, hresp;
	logic chip_enable_in_n, watchdog_kick_in;
	logic [9:0] pins;
	int miscompares = 0, comparisons = 0;

	bmg_top uut (.clk_sys, .rstn, .supply_below_reset, .switchover_comparator, .power_fail_comparator,
		.chip_enable_in_n, .reset_req_n, .watchdog_exp_req_n, .watchdog_kick_in, .timebase_in,
		.timebase_select, .backup_active_flag, .power_fail_warn_n, .reset_out_n, .reset_out,
		.supply_ok_n_low, .watchdog_expired_n, .chip_enable_out_n, .watchdog_kick_out, .timebase_out,
		.timebase_select_out, .irq, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp);
	bmg_cpu_model cpu (.clk_sys, .rstn, .power_fail_warn_n, .stray_drive, .chip_enable_in_n, .watchdog_kick_in);

	////////////////////////////////////////////////////////////////////////////
	initial forever #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cnt <= cnt + 4'h1;
		{watchdog_exp_req_n, reset_req_n, timebase_select, timebase_in} <= cnt;
	end
	assign pins = {backup_active_flag, power_fail_warn_n, reset_out_n, reset_out, supply_ok_n_low,
		watchdog_expired_n, chip_enable_out_n, watchdog_kick_out, timebase_out, timebase_select_out};

	function automatic logic [9:0] exp_pins(input logic [8:0] v);
		if (v[8])
			return 10'h259;
		return {1'b0, ~v[6], v[4], ~v[4], ~v[7], v[3], v[7] | v[5], v[2:0]};
	endfunction
	// Inputs seen between two edges show at the outputs after the second one
	always @(negedge clk_sys) begin
		if (pin_chk) `CHK(pins, exp_pins(prev))
		prev = {switchover_comparator, supply_below_reset, power_fail_comparator, chip_enable_in_n,
			reset_req_n, watchdog_exp_req_n, watchdog_kick_in, timebase_in, timebase_select};
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
		// Called right after a rising edge; every change is a non-blocking one
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {20'h0_0000, a};
		do begin @(posedge clk_sys); end while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do begin @(posedge clk_sys); end while (hreadyout !== 1'b1);
		rd = hrdata;
		`CHK(hresp, `BMG_HRESP_OKAY)
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0000_0000, r);
		`CHK(r & m, e)
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wrap_up;
		if (miscompares == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		// Whole sequence takes well under a thousand cycles
		#50000;
		miscompares++;
		wrap_up;
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		wt(2);
		pin_chk = 1'b1;
		wr(`BMG_OFF_IRQ_CLR, 32'h0000_000f);
		rd(`BMG_OFF_STATUS, 32'hffff_ffff, 32'h0000_0000);
		rd(`BMG_OFF_IRQ_EN, 32'hffff_ffff, 32'h0000_0000);
		rd(`BMG_OFF_BACKUP_CNT, 32'hffff_ffff, 32'h0000_0000);
		rd(12'h020, 32'hffff_ffff, 32'h0000_0000);
		wr(`BMG_OFF_STATUS, 32'h0000_000f);
		rd(`BMG_OFF_STATUS, 32'hffff_ffff, 32'h0000_0000);
		wr(`BMG_OFF_IRQ_EN, 32'h0000_0001);
		rd(`BMG_OFF_IRQ_EN, 32'hffff_ffff, 32'h0000_0001);
		stray_drive <= 1'b1;
		switchover_comparator <= 1'b1;
		power_fail_comparator <= 1'b1;
		wt(6);
		`CHK(irq, 1'b1)
		rd(`BMG_OFF_STATUS, 32'h0000_0007, 32'h0000_0001);
		rd(`BMG_OFF_LEVELS, 32'h0000_000d, 32'h0000_0009);
		// Sense swings while in back-up; the pin check must see no effect
		power_fail_comparator <= 1'b0;
		rd(`BMG_OFF_BACKUP_CNT, 32'hffff_ffff, 32'h0000_0001);
		stray_drive <= 1'b0;
		switchover_comparator <= 1'b0;
		power_fail_comparator <= 1'b0;
		wt(3);
		rd(`BMG_OFF_STATUS, 32'h0000_0003, 32'h0000_0003);
		wr(`BMG_OFF_IRQ_CLR, 32'h0000_000f);
		wt(2);
		`CHK(irq, 1'b0)
		rd(`BMG_OFF_STATUS, 32'hffff_ffff, 32'h0000_0000);
		wr(`BMG_OFF_IRQ_EN, 32'h0000_0000);
		power_fail_comparator <= 1'b1;
		wt(3);
		`CHK(irq, 1'b0)
		rd(`BMG_OFF_STATUS, 32'h0000_0004, 32'h0000_0004);
		wr(`BMG_OFF_IRQ_EN, 32'h0000_0004);
		wt(2);
		`CHK(irq, 1'b1)
		wr(`BMG_OFF_IRQ_CLR, 32'h0000_0004);
		wt(2);
		`CHK(irq, 1'b0)
		power_fail_comparator <= 1'b0;
		supply_below_reset <= 1'b1;
		wt(4);
		rd(`BMG_OFF_STATUS, 32'h0000_0008, 32'h0000_0008);
		rd(`BMG_OFF_LEVELS, 32'h0000_000a, 32'h0000_000a);
		supply_below_reset <= 1'b0;
		repeat (2) begin
			switchover_comparator <= 1'b1;
			wt(3);
			switchover_comparator <= 1'b0;
			wt(3);
		end
		rd(`BMG_OFF_BACKUP_CNT, 32'hffff_ffff, 32'h0000_0003);
		wrap_up;
	end
endmodule
